// >>> common/dbdc_pkg.sv
package dbdc_pkg;
   localparam logic [7:0] BOOT_SRC_OFS   = 8'h32;
   localparam logic [7:0] SW_INT_OFS     = 8'h33;
   localparam logic [7:0] MEM_CFG_OFS    = 8'h34;
   localparam logic [7:0] DEC_RST_OFS    = 8'h35;
   localparam int         BOOT_RAM_BIT   = 1;
   localparam int         COEF_DEF_BIT   = 0;
   localparam int         SW_INT_BIT     = 0;
   localparam int         RD_EN_BIT      = 3;
   localparam int         DEC_DIS_BIT    = 2;
   localparam int         SEED_LSB       = 0;
   localparam int         DEC_RST_BIT    = 0;
   localparam logic [7:0] BOOT_SRC_RST   = 8'h00;
   localparam logic [7:0] SW_INT_RST     = 8'h00;
   localparam logic [7:0] MEM_CFG_RST    = 8'h00;
   localparam logic [7:0] SEED_0         = 8'hA5;
   localparam logic [7:0] SEED_1         = 8'hB6;
   localparam logic [7:0] SEED_2         = 8'h94;
   localparam logic [7:0] SEED_3         = 8'hE2;
   localparam logic [7:0] CRC_POLY       = 8'h07;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dbdc_req_s;

   typedef struct packed {
      logic       boot_from_ram_select;
      logic       default_coefficient_select;
      logic       internal_memory_read_enable;
      logic       decryption_disable;
      logic [1:0] crc_seed_select;
   } dbdc_cfg_s;

   function automatic logic [7:0] dbdc_seed(input logic [1:0] sel);
      case (sel)
         2'h0:    dbdc_seed = SEED_0;
         2'h1:    dbdc_seed = SEED_1;
         2'h2:    dbdc_seed = SEED_2;
         default: dbdc_seed = SEED_3;
      endcase
   endfunction : dbdc_seed
endpackage : dbdc_pkg

// >>> core/dbdc_regs.sv
`timescale 1ns/1ns
module dbdc_regs
   import dbdc_pkg::*;
(
   input  wire logic       clk,            // 20 MHz system clock
   input  wire logic       rstn,           // Async reset, active low
   input  wire dbdc_req_s  req,            // Control port access, one cycle strobes
   output logic [7:0]      rdata,          // Register read data, valid cycle after rd
   input  wire logic       core_int_ack,   // DSP core acknowledges the interrupt
   output logic            core_software_interrupt, // Interrupt request to core
   output logic            boot_from_ram_select,    // Boot source to core
   output logic            default_coefficient_select, // Coefficient source
   input  wire logic       mem_rd,         // Internal memory read request
   input  wire logic [7:0] mem_raw,        // Raw memory word
   output logic [7:0]      mem_rdata,      // Gated memory read data
   input  wire logic       dl_valid,       // Downloaded byte for instruction RAM
   input  wire logic [7:0] dl_data,        // Downloaded byte
   output logic            instruction_ram_we,        // Write strobe to instruction RAM
   output logic [7:0]      instruction_ram_wdata      // Decrypted or plain byte
);
   logic       rst_s1;
   logic       rst_s2;
   dbdc_cfg_s  cfg;
   dbdc_cfg_s  next_cfg;
   logic       next_int;
   logic [7:0] crc;
   logic [7:0] next_crc;
   logic [7:0] next_rdata;
   logic [7:0] next_mem_rdata;
   logic       next_instruction_ram_we;
   logic [7:0] next_instruction_ram_wdata;
   logic       wr_boot;
   logic       wr_int;
   logic       wr_cfg;
   logic       dec_rst;

   // Reset image of the stored fields, built from the register reset values
   localparam dbdc_cfg_s CFG_RST = '{
      boot_from_ram_select:        BOOT_SRC_RST[BOOT_RAM_BIT],
      default_coefficient_select:  BOOT_SRC_RST[COEF_DEF_BIT],
      internal_memory_read_enable: MEM_CFG_RST[RD_EN_BIT],
      decryption_disable:          MEM_CFG_RST[DEC_DIS_BIT],
      crc_seed_select:             MEM_CFG_RST[SEED_LSB +: 2]
   };

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // One CRC-8 step per byte; key stream is the CRC state
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      crc_step = r;
   endfunction : crc_step

   // Offset match shared by the write strobes and the checks below
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = addr == ofs;
   endfunction : reg_hit

   assign wr_boot = req.wr && reg_hit(req.addr, BOOT_SRC_OFS);
   assign wr_int  = req.wr && reg_hit(req.addr, SW_INT_OFS);
   assign wr_cfg  = req.wr && reg_hit(req.addr, MEM_CFG_OFS);
   assign dec_rst = req.wr && reg_hit(req.addr, DEC_RST_OFS) && req.wdata[DEC_RST_BIT];

   always_comb begin
      next_cfg = cfg;
      if (wr_boot) begin
         next_cfg.boot_from_ram_select       = req.wdata[BOOT_RAM_BIT];
         next_cfg.default_coefficient_select = req.wdata[COEF_DEF_BIT];
      end
      if (wr_cfg) begin
         next_cfg.internal_memory_read_enable = req.wdata[RD_EN_BIT];
         next_cfg.decryption_disable          = req.wdata[DEC_DIS_BIT];
         next_cfg.crc_seed_select             = req.wdata[SEED_LSB +: 2];
      end
   end

   // Host set wins over an acknowledge in the same cycle
   always_comb begin
      next_int = core_software_interrupt;
      if (core_int_ack)
         next_int = 1'b0;
      if (wr_int && req.wdata[SW_INT_BIT])
         next_int = 1'b1;
   end

   always_comb begin
      next_rdata = 8'h00;
      if (req.rd) begin
         case (req.addr)
            BOOT_SRC_OFS: next_rdata = {6'h00, cfg.boot_from_ram_select,
                                        cfg.default_coefficient_select};
            SW_INT_OFS:   next_rdata = {7'h00, core_software_interrupt};
            MEM_CFG_OFS:  next_rdata = {4'h0, cfg.internal_memory_read_enable,
                                        cfg.decryption_disable, cfg.crc_seed_select};
            default:      next_rdata = 8'h00;
         endcase
      end
      next_mem_rdata = (mem_rd && cfg.internal_memory_read_enable) ? mem_raw : 8'h00;
   end

   // Reset from the register loads the seed picked by next_cfg, so a seed write in the same cycle would already count
   always_comb begin
      next_crc        = crc;
      next_instruction_ram_we    = dl_valid;
      next_instruction_ram_wdata = dl_data;
      if (dl_valid && !cfg.decryption_disable) begin
         next_instruction_ram_wdata = dl_data ^ crc;
         next_crc        = crc_step(crc, dl_data);
      end
      if (dec_rst)
         next_crc = dbdc_seed(next_cfg.crc_seed_select);
   end

   always_ff @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         cfg                     <= CFG_RST;
         core_software_interrupt <= SW_INT_RST[SW_INT_BIT];
         crc                     <= SEED_0;
         rdata                   <= 8'h00;
         mem_rdata               <= 8'h00;
         instruction_ram_we                 <= 1'b0;
         instruction_ram_wdata              <= 8'h00;
      end else begin
         cfg                     <= next_cfg;
         core_software_interrupt <= next_int;
         crc                     <= next_crc;
         rdata                   <= next_rdata;
         mem_rdata               <= next_mem_rdata;
         instruction_ram_we                 <= next_instruction_ram_we;
         instruction_ram_wdata              <= next_instruction_ram_wdata;
      end
   end

   assign boot_from_ram_select       = cfg.boot_from_ram_select;
   assign default_coefficient_select = cfg.default_coefficient_select;

   boot_sel_a: assert property (@(posedge clk) disable iff (!rst_s2)
      wr_boot |=> boot_from_ram_select == $past(req.wdata[BOOT_RAM_BIT]))
      else $error("boot source not taken");
   coef_sel_a: assert property (@(posedge clk) disable iff (!rst_s2)
      wr_boot |=> default_coefficient_select == $past(req.wdata[COEF_DEF_BIT]))
      else $error("coefficient source not taken");
   int_set_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (wr_int && req.wdata[SW_INT_BIT]) |=> core_software_interrupt)
      else $error("interrupt not raised");
   int_clr_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (core_int_ack && !wr_int) |=> !core_software_interrupt)
      else $error("interrupt not cleared on ack");
   mem_gate_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !cfg.internal_memory_read_enable |=> mem_rdata == 8'h00)
      else $error("memory read not gated");
   plain_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dl_valid && cfg.decryption_disable) |=> instruction_ram_we && instruction_ram_wdata == $past(dl_data))
      else $error("plain store altered");
   seed_load_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h2 && !wr_cfg) |=> crc == SEED_2)
      else $error("wrong seed loaded");
   decrypt_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dl_valid && !cfg.decryption_disable) |=> instruction_ram_wdata == ($past(dl_data) ^ $past(crc)))
      else $error("decryption key wrong");
   rst_read_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (req.rd && req.addr == DEC_RST_OFS) |=> rdata == 8'h00)
      else $error("reset bit reads nonzero");

   // Stored fields hold still unless their own register is written
   boot_keep_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !wr_boot |=> $stable(boot_from_ram_select))
      else $error("boot source changed without a write");

   coef_keep_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !wr_boot |=> $stable(default_coefficient_select))
      else $error("coefficient source changed without a write");

   rd_en_keep_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !wr_cfg |=> $stable(cfg.internal_memory_read_enable))
      else $error("read enable changed without a write");

   dis_keep_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !wr_cfg |=> $stable(cfg.decryption_disable))
      else $error("decryption mode changed without a write");

   seed_keep_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !wr_cfg |=> $stable(cfg.crc_seed_select))
      else $error("seed select changed without a write");

   // Read-back shows the stored bits, reserved positions at 0
   boot_read_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (req.rd && req.addr == BOOT_SRC_OFS) |=>
         rdata == {6'h00, $past(boot_from_ram_select), $past(default_coefficient_select)})
      else $error("boot register read back wrong");

   cfg_read_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (req.rd && req.addr == MEM_CFG_OFS) |=>
         rdata == {4'h0, $past(cfg.internal_memory_read_enable),
                   $past(cfg.decryption_disable), $past(cfg.crc_seed_select)})
      else $error("memory config read back wrong");

   int_read_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (req.rd && req.addr == SW_INT_OFS) |=>
         rdata == {7'h00, $past(core_software_interrupt)})
      else $error("interrupt bit read back wrong");

   // A zero write or an idle cycle leaves a pending interrupt alone
   int_hold_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (!core_int_ack && !(wr_int && req.wdata[SW_INT_BIT])) |=>
         $stable(core_software_interrupt))
      else $error("interrupt changed with no set or acknowledge");

   int_zero_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (wr_int && !req.wdata[SW_INT_BIT] && !core_int_ack && core_software_interrupt) |=>
         core_software_interrupt)
      else $error("zero write cleared the interrupt");

   int_fall_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (core_int_ack && core_software_interrupt && !wr_int) |=>
         $fell(core_software_interrupt))
      else $error("pending interrupt not dropped on ack");

   // Open gate passes the raw word; no request gives 0 either way
   mem_pass_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (mem_rd && cfg.internal_memory_read_enable) |=> mem_rdata == $past(mem_raw))
      else $error("enabled memory read altered");

   mem_idle_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !mem_rd |=> mem_rdata == 8'h00)
      else $error("memory data without a request");

   // Every downloaded byte is written exactly once, decrypted or not
   we_follow_a: assert property (@(posedge clk) disable iff (!rst_s2)
      dl_valid |=> instruction_ram_we)
      else $error("downloaded byte not written");

   we_idle_a: assert property (@(posedge clk) disable iff (!rst_s2)
      !dl_valid |=> !instruction_ram_we)
      else $error("write strobe without a byte");

   crc_hold_a: assert property (@(posedge clk) disable iff (!rst_s2)
      ((!dl_valid || cfg.decryption_disable) && !dec_rst) |=> $stable(crc))
      else $error("key state moved with no decrypted byte");

   rst_keep_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (req.wr && reg_hit(req.addr, DEC_RST_OFS) && !req.wdata[DEC_RST_BIT] && !dl_valid) |=>
         $stable(crc))
      else $error("zero write disturbed the key state");

   // Each seed code loads its own seed
   seed_zero_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h0) |=> crc == SEED_0)
      else $error("seed code 0 loaded wrong seed");

   seed_one_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h1) |=> crc == SEED_1)
      else $error("seed code 1 loaded wrong seed");

   seed_three_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h3) |=> crc == SEED_3)
      else $error("seed code 3 loaded wrong seed");

   // The first byte after a reset write and one quiet cycle is keyed by the seed;
   // a byte in the quiet cycle would advance the state, so it is excluded
   key_zero_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h0) ##1 (!dl_valid && !dec_rst) ##1
         (dl_valid && !cfg.decryption_disable && !dec_rst) |=>
         instruction_ram_wdata == ($past(dl_data) ^ SEED_0))
      else $error("first key after reset is not seed 0");

   key_one_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h1) ##1 (!dl_valid && !dec_rst) ##1
         (dl_valid && !cfg.decryption_disable && !dec_rst) |=>
         instruction_ram_wdata == ($past(dl_data) ^ SEED_1))
      else $error("first key after reset is not seed 1");

   key_two_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h2) ##1 (!dl_valid && !dec_rst) ##1
         (dl_valid && !cfg.decryption_disable && !dec_rst) |=>
         instruction_ram_wdata == ($past(dl_data) ^ SEED_2))
      else $error("first key after reset is not seed 2");

   key_three_a: assert property (@(posedge clk) disable iff (!rst_s2)
      (dec_rst && cfg.crc_seed_select == 2'h3) ##1 (!dl_valid && !dec_rst) ##1
         (dl_valid && !cfg.decryption_disable && !dec_rst) |=>
         instruction_ram_wdata == ($past(dl_data) ^ SEED_3))
      else $error("first key after reset is not seed 3");
endmodule : dbdc_regs

// >>> bench/dbdc_host.sv
`timescale 1ns/1ns
module dbdc_host
   import dbdc_pkg::*;
(
   input  wire logic clk, // System clock
   output dbdc_req_s req  // Control port strobes
);
   initial req = '0;
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{w, !w, a, d};
      @(posedge clk);
      #1 req = '0;
   endtask : acc
   // Seed and mode go first, so the pulse loads the key for the first byte
   task automatic arm(input logic [7:0] cfg);
      acc(1'b1, MEM_CFG_OFS, cfg);
      acc(1'b1, DEC_RST_OFS, 8'h01);
   endtask : arm
endmodule : dbdc_host

// >>> bench/testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   import dbdc_pkg::*;
   logic       clk = 1'b0, rstn = 1'b0, ack = 1'b0, mem_rd = 1'b0, dl_valid = 1'b0;
   logic [7:0] mem_raw = '0, dl_data = '0, rdata, mem_rdata, instruction_ram_wdata, crc, e;
   logic       cint, boot, coef, instruction_ram_we, rd_d = 1'b0, mr_d = 1'b0;
   dbdc_req_s  req;
   logic [7:0] q[$];
   logic [7:0] seeds[4] = '{SEED_0, SEED_1, SEED_2, SEED_3};
   int         failures = 0, compares = 0;
   always #25 clk = ~clk;
   dbdc_host host_u (.clk(clk), .req(req));
   dbdc_regs dut_u (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .core_int_ack(ack),
      .core_software_interrupt(cint), .boot_from_ram_select(boot),
      .default_coefficient_select(coef), .mem_rd(mem_rd), .mem_raw(mem_raw),
      .mem_rdata(mem_rdata), .dl_valid(dl_valid), .dl_data(dl_data), .instruction_ram_we(instruction_ram_we),
      .instruction_ram_wdata(instruction_ram_wdata));
   // Results are never overlapped by the stimulus, so one queue keeps their order
   always @(posedge clk) begin
      rd_d <= req.rd;
      mr_d <= mem_rd;
      if (rd_d || mr_d || instruction_ram_we === 1'b1) begin
         if (q.size() == 0) begin
            failures++;
            $display("[ERR] %0t unexpected result", $time);
         end else begin
            e = q.pop_front();
            `CHK(rd_d ? rdata : mr_d ? mem_rdata : instruction_ram_wdata, e)
         end
      end
   end
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] x);
      logic [7:0] v;
      v = c ^ x;
      repeat (8) v = v[7] ? ((v << 1) ^ CRC_POLY) : (v << 1);
      return v;
   endfunction : crc_step
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      q.push_back(x);
      host_u.acc(1'b0, a, 8'h00);
   endtask : rd
   task automatic mrd(input logic en);
      @(posedge clk);
      #1 mem_rd = 1'b1;
      mem_raw = 8'($urandom);
      q.push_back(en ? mem_raw : 8'h00);
      @(posedge clk);
      #1 mem_rd = 1'b0;
   endtask : mrd
   task automatic dl(input logic dis, input int n);
      repeat (n) begin
         @(posedge clk);
         #1 dl_valid = 1'b1;
         dl_data = 8'($urandom);
         q.push_back(dis ? dl_data : dl_data ^ crc);
         crc = crc_step(crc, dl_data);
      end
      @(posedge clk);
      #1 dl_valid = 1'b0;
   endtask : dl
   task automatic finish_test;
      if (q.size() != 0) failures++;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      $display("[ERR] %0t timeout", $time);
      finish_test;
   end
   initial begin
      void'($urandom(25840));
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 8'h32; a <= 8'h36; a++) rd(8'(a), 8'h00);
      for (int v = 0; v < 4; v++) begin
         host_u.acc(1'b1, BOOT_SRC_OFS, 8'(v) | 8'hFC);
         `CHK(boot, v[1])
         `CHK(coef, v[0])
         rd(BOOT_SRC_OFS, 8'(v));
      end
      host_u.acc(1'b1, SW_INT_OFS, 8'h01);
      `CHK(cint, 1'b1)
      host_u.acc(1'b1, SW_INT_OFS, 8'h00);
      `CHK(cint, 1'b1)
      rd(SW_INT_OFS, 8'h01);
      @(posedge clk);
      #1 ack = 1'b1;
      @(posedge clk);
      #1 ack = 1'b0;
      `CHK(cint, 1'b0)
      host_u.acc(1'b1, 8'h36, 8'hFF);
      rd(8'h36, 8'h00);
      mrd(1'b0);
      host_u.acc(1'b1, MEM_CFG_OFS, 8'h08);
      mrd(1'b1);
      for (int s = 0; s < 4; s++) begin
         host_u.arm(8'(s) | 8'h08);
         crc = seeds[s];
         dl(1'b0, 3);
      end
      host_u.acc(1'b1, DEC_RST_OFS, 8'h01);
      crc = seeds[3];
      dl(1'b0, 2);
      host_u.acc(1'b1, DEC_RST_OFS, 8'h00);
      dl(1'b0, 2);
      host_u.arm(8'h0C);
      dl(1'b1, 2);
      rd(MEM_CFG_OFS, 8'h0C);
      rd(DEC_RST_OFS, 8'h00);
      repeat (3) @(posedge clk);
      finish_test;
   end
endmodule : testbench
